// *** playback_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module playback_far_model
  import playback_pkg::*;
  (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic        mem_rd_i,
    output var mem_word_type mem_data_o,
    output logic             dac_ready_o
  );
  logic [7:0] lfsr_reg;
  // Markers from the top address bits, constant over a short segment
  function automatic mem_word_type sample_word(logic [15:0] a);
    return {a[15:14], ~a[7:0], a[7:0] ^ 8'hA5, a[15:8], a[7:0]};
  endfunction
  initial
  begin
    mem_data_o = '0;
    dac_ready_o = 1'b0;
    lfsr_reg = 8'h01;
  end
  // Word valid only the cycle after a fetch; inverted junk otherwise
  always @(posedge ref_clk_i)
    mem_data_o <= mem_rd_i ? sample_word(mem_addr_i) : ~mem_data_o;
  // Sink stalls about one cycle in four, so holding gets exercised
  always @(posedge ref_clk_i)
  begin
    lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    dac_ready_o <= rst_n_i && (|lfsr_reg[1:0]);
  end
endmodule
`default_nettype wire

// *** playback_fifo.sv ***
// The sample queue module sits beside the run control logic in its file

// *** playback_params.svh ***
`ifndef PLAYBACK_PARAMS_SVH
`define PLAYBACK_PARAMS_SVH

// Widths and sizes
`define SAMPLE_W        8
`define ADDR_W          16
`define REG_ADDR_W      4
`define DATA_W          32
`define FIFO_DEPTH      8
`define MARKER_BLOCK    128
`define BLOCK_CNT_W     7
`define SKEW_W          4
`define SKEW_DEPTH      16

// Register offsets (word index on the plain port)
`define REG_CTRL        4'h0
`define REG_SEG_START   4'h1
`define REG_SEG_LEN     4'h2
`define REG_SKEW        4'h3
`define REG_STATUS      4'h4

// Control register fields
`define CTRL_RUN_BIT    0
`define CTRL_EXT_BIT    1
`define CTRL_MODE_LSB   2
`define CTRL_CFG_LSB    4
`define CTRL_POL_BIT    7

// Reset values
`define CTRL_RST        32'h0000_0000
`define SEG_LEN_RST     16'h0001

`endif

// *** playback_pkg.sv ***
package playback_pkg;

  typedef enum logic [1:0]
  {
    RUN_CONTINUOUS = 2'h0,
    RUN_TRIGGERED  = 2'h1,
    RUN_GATED      = 2'h2
  } run_mode_type;

  typedef enum logic [2:0]
  {
    CFG_SINGLE     = 3'h0,
    CFG_SINGLE_MKR = 3'h1,
    CFG_DUAL       = 3'h2,
    CFG_DUAL_MKR   = 3'h3,
    CFG_DUAL_DUP   = 3'h4,
    CFG_FOUR       = 3'h5
  } chan_cfg_type;

  // One memory word: four channel samples plus two marker bits
  typedef struct packed
  {
    logic [1:0] marker;
    logic [7:0] ch4;
    logic [7:0] ch3;
    logic [7:0] ch2;
    logic [7:0] ch1;
  } mem_word_type;

  // Per-channel outputs to the converters
  typedef struct packed
  {
    logic [7:0] ch4;
    logic [7:0] ch3;
    logic [7:0] ch2;
    logic [7:0] ch1;
  } dac_word_type;

endpackage

// *** waveform_playback_run_control.sv ***
// Summary of operation
// - Continuous, internal memory: loop the segment without pause while running.
// - Continuous, extended memory: repeat the segment without pause.
// - Triggered, internal memory: wait for trigger, then loop forever.
// - Triggered, extended memory: play the selection once per trigger.
// - Gated, internal memory: start looping on a gate rising edge.
// - Gated, extended memory: play only while the gate is high.
// - Two markers with complements only in the two marker configurations.
// - Markers only when samples come from extended memory.
// - Markers and complements leave on marker_o and marker_n_o, apart from the channel outputs.
// - Every other configuration produces no markers.
// - Marker bits ride beside sample data; full sample width kept.
// - Marker edges per sample; at most one rise and fall per 128, which the waveform must keep, as the logic does not enforce it.
// - Duplicate mode copies channel 1 to 2 and channel 4 to 3.
// - Duplicate copies are delayed by a programmable skew.
`timescale 1ns/1ps
`default_nettype none

`include "playback_params.svh"

module waveform_playback_run_control
  import playback_pkg::*;
  #(
    parameter int ADDR_W     = `ADDR_W,
    parameter int FIFO_DEPTH = `FIFO_DEPTH,
    parameter int SKEW_DEPTH = `SKEW_DEPTH
  )
  (
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_n_i,
    // Register port
    input  wire logic [`REG_ADDR_W-1:0] reg_addr_i,
    input  wire logic [`DATA_W-1:0]     reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [`DATA_W-1:0]     reg_rdata_o,
    // Trigger/gate pin
    input  wire logic                   trig_gate_i,
    // Sample memory read port, one cycle latency
    output logic      [ADDR_W-1:0]      mem_addr_o,
    output logic                        mem_rd_o,
    input  wire mem_word_type           mem_data_i,
    // Converter side
    output var dac_word_type            dac_data_o,
    output logic                        dac_valid_o,
    input  wire logic                   dac_ready_i,
    output logic      [1:0]             marker_o,
    output logic      [1:0]             marker_n_o
  );

  localparam int FW = $bits(mem_word_type);

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_ARMED,
    ST_PLAY
  } play_state_type;

  play_state_type   state_reg;
  logic [`DATA_W-1:0] ctrl_reg;
  logic [ADDR_W-1:0] seg_start_reg;
  logic [ADDR_W-1:0] seg_len_reg;
  logic [`SKEW_W-1:0] skew_reg;
  logic [ADDR_W-1:0] offset_reg;
  logic             trig_meta_reg;
  logic             trig_sync_reg;
  logic             trig_prev_reg;
  logic             rd_pend_reg;
  logic [31:0]      pass_cnt_reg;
  logic [`DATA_W-1:0] rdata_reg;

  run_mode_type     mode;
  chan_cfg_type     cfg;
  logic             run_en;
  logic             ext_mem;
  logic             gate;
  logic             gate_rise;
  logic             gate_fall;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [FW-1:0]    fifo_out_data;
  mem_word_type     word;
  logic             last_addr;
  logic             fetch;
  logic             markers_on;
  logic             advance;

  // Control fields decoded once for everyone below
  assign mode    = run_mode_type'(ctrl_reg[`CTRL_MODE_LSB +: 2]);
  assign cfg     = chan_cfg_type'(ctrl_reg[`CTRL_CFG_LSB +: 3]);
  assign run_en  = ctrl_reg[`CTRL_RUN_BIT];
  assign ext_mem = ctrl_reg[`CTRL_EXT_BIT];

  // Pin passes two flops before use; polarity applied after the second
  // Only the second flop feeds logic, so a metastable first flop never spreads
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end
    else
    begin
      trig_meta_reg <= trig_gate_i;
      trig_sync_reg <= trig_meta_reg;
      trig_prev_reg <= gate;
    end
  end

  // Trigger edges as seen after polarity
  // Flipping polarity while armed looks like an edge; change it while stopped
  assign gate      = trig_sync_reg ^ ctrl_reg[`CTRL_POL_BIT];
  assign gate_rise = gate && !trig_prev_reg;
  assign gate_fall = !gate && trig_prev_reg;

  // Register writes
  // Unmapped indices fall through untouched
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_reg      <= `CTRL_RST;
      seg_start_reg <= '0;
      seg_len_reg   <= ADDR_W'(`SEG_LEN_RST);
      skew_reg      <= '0;
    end
    else if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        `REG_CTRL:      ctrl_reg      <= reg_wdata_i;
        `REG_SEG_START: seg_start_reg <= reg_wdata_i[ADDR_W-1:0];
        `REG_SEG_LEN:   seg_len_reg   <= reg_wdata_i[ADDR_W-1:0];
        `REG_SKEW:      skew_reg      <= reg_wdata_i[`SKEW_W-1:0];
        default:        ;
      endcase
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      rdata_reg <= '0;
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `REG_CTRL:      rdata_reg <= ctrl_reg;
        `REG_SEG_START: rdata_reg <= `DATA_W'(seg_start_reg);
        `REG_SEG_LEN:   rdata_reg <= `DATA_W'(seg_len_reg);
        `REG_SKEW:      rdata_reg <= `DATA_W'(skew_reg);
        `REG_STATUS:    rdata_reg <= {pass_cnt_reg[27:0], gate, 1'b0, state_reg};
        default:        rdata_reg <= '0;
      endcase
    end
    else
      rdata_reg <= '0;
  end
  assign reg_rdata_o = rdata_reg;

  // Zero length acts as one, so the walk never runs off the segment
  assign last_addr = (offset_reg == seg_len_reg - 1'b1) || (seg_len_reg == '0);

  // Playback sequencing per run mode and memory kind
  // Clearing run drops straight back to idle from any state
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || !run_en)
      state_reg <= ST_IDLE;
    else
    begin
      unique case (state_reg)
        ST_IDLE:
          state_reg <= (mode == RUN_CONTINUOUS) ? ST_PLAY : ST_ARMED;
        ST_ARMED:
          if (mode == RUN_CONTINUOUS)
            state_reg <= ST_PLAY;
          else if (mode == RUN_GATED && ext_mem && gate)
            state_reg <= ST_PLAY;
          else if (gate_rise)
            state_reg <= ST_PLAY;
        ST_PLAY:
          if (mode == RUN_GATED && ext_mem && gate_fall)
            state_reg <= ST_ARMED;
          else if (mode == RUN_TRIGGERED && ext_mem && fetch && last_addr)
            state_reg <= ST_ARMED;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Fetch only while the queue has room for the word in flight
  // One read in flight at a time, so the returning word always finds a slot
  assign fetch = (state_reg == ST_PLAY) && fifo_in_ready && !rd_pend_reg
                 && !(mode == RUN_GATED && ext_mem && !gate);

  // Address walk; wraps for looping, counts whole passes
  // Gated pause keeps the offset, so playback resumes where it stopped
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || state_reg == ST_IDLE)
    begin
      offset_reg   <= '0;
      pass_cnt_reg <= '0;
      rd_pend_reg  <= 1'b0;
    end
    else
    begin
      rd_pend_reg <= fetch;
      if (fetch)
      begin
        offset_reg <= last_addr ? '0 : offset_reg + 1'b1;
        if (last_addr)
          pass_cnt_reg <= pass_cnt_reg + 32'h0000_0001;
      end
      else if (state_reg == ST_ARMED && mode == RUN_TRIGGERED)
        offset_reg <= '0;
    end
  end

  assign mem_addr_o = seg_start_reg + offset_reg;
  assign mem_rd_o   = fetch;

  // Buffer decouples memory latency from converter back-pressure
  playback_fifo
    #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
    )
    u_fifo
    (
      .ref_clk_i   (ref_clk_i),
      .rst_n_i     (rst_n_i),
      .flush_i     (state_reg == ST_IDLE),
      .in_data_i   (mem_data_i),
      .in_valid_i  (rd_pend_reg),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_out_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (advance)
    );

  assign word = mem_word_type'(fifo_out_data);

  // Held output stage: in gated extended mode, gate low stops the queue draining
  assign advance = fifo_out_valid && (!dac_valid_o || dac_ready_i)
                   && !(mode == RUN_GATED && ext_mem && !gate);

  // Marker lanes stay quiet unless memory kind and setup both allow them
  assign markers_on = ext_mem && (cfg == CFG_SINGLE_MKR || cfg == CFG_DUAL_MKR);

  // Skew line for the duplicate copies
  // Shifts only on accepted words, so skew counts samples, not clocks
  // Left unreset: it holds real samples once anything has played
  logic [7:0] dly1_reg [SKEW_DEPTH];
  logic [7:0] dly4_reg [SKEW_DEPTH];

  always_ff @(posedge ref_clk_i)
  begin
    if (advance)
    begin
      dly1_reg[0] <= word.ch1;
      dly4_reg[0] <= word.ch4;
      for (int i = 1; i < SKEW_DEPTH; i++)
      begin
        dly1_reg[i] <= dly1_reg[i-1];
        dly4_reg[i] <= dly4_reg[i-1];
      end
    end
  end

  // Output registers; markers ride outside the sample lanes
  // A stalled word stays put until the sink takes it
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || state_reg == ST_IDLE)
    begin
      dac_data_o  <= '0;
      dac_valid_o <= 1'b0;
      marker_o    <= 2'h0;
      marker_n_o  <= 2'h3;
    end
    else if (advance)
    begin
      dac_valid_o    <= 1'b1;
      dac_data_o.ch1 <= word.ch1;
      dac_data_o.ch4 <= word.ch4;
      if (cfg == CFG_DUAL_DUP)
      begin
        // Skew zero gives the copy in step with the original
        dac_data_o.ch2 <= (skew_reg == '0) ? word.ch1 : dly1_reg[skew_reg - 1'b1];
        dac_data_o.ch3 <= (skew_reg == '0) ? word.ch4 : dly4_reg[skew_reg - 1'b1];
      end
      else
      begin
        dac_data_o.ch2 <= word.ch2;
        dac_data_o.ch3 <= word.ch3;
      end
      // Edge spacing within a block is the waveform author's duty
      marker_o   <= markers_on ? word.marker : 2'h0;
      marker_n_o <= markers_on ? ~word.marker : 2'h3;
    end
    else if (dac_ready_i)
      dac_valid_o <= 1'b0;
  end

endmodule

// Sample queue between memory fetches and the converter stage
module playback_fifo
  #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 8
  )
  (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             flush_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
  );

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count
  // Count is one bit wider than the pointers so full and empty stay distinct
  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage array; not reset, only read where the count says it holds data
  always_ff @(posedge ref_clk_i)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data_i;
  end

  // Pointers and count; flush drops everything queued
  // Pointers wrap by compare, so the depth need not be a power of two
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || flush_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

`default_nettype wire

// *** waveform_playback_run_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "playback_params.svh"
module waveform_playback_run_control_bench;
  import playback_pkg::*;
  logic         clk, rst_n, wr, rd, gate, mrd, dv, drdy;
  logic [3:0]   addr, sk;
  logic [31:0]  wdata, rdata, rv;
  logic [15:0]  maddr, s, l;
  mem_word_type md;
  dac_word_type dd;
  logic [1:0]   mk, mkn;
  logic [33:0]  q[$];
  int           mismatches, checks_done, k, n;
  waveform_playback_run_control u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .trig_gate_i(gate),
    .mem_addr_o(maddr), .mem_rd_o(mrd), .mem_data_i(md), .dac_data_o(dd), .dac_valid_o(dv),
    .dac_ready_i(drdy), .marker_o(mk), .marker_n_o(mkn));
  playback_far_model u_far (.ref_clk_i(clk), .rst_n_i(rst_n), .mem_addr_i(maddr),
    .mem_rd_i(mrd), .mem_data_o(md), .dac_ready_o(drdy));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Every word the sink accepts is queued with its markers
  always @(posedge clk)
    if (rst_n && dv && drdy)
      q.push_back({mk, dd});
  task automatic chk(string what, logic [33:0] exp, logic [33:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Stop, flush, then start a new segment; start keeps top bits fixed
  task automatic play(logic [15:0] len, logic [7:0] c);
    wr_reg(`REG_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    q.delete();
    k = 0;
    s = {2'($urandom), 6'h00, 8'($urandom)};
    wr_reg(`REG_SEG_START, {16'h0, s});
    wr_reg(`REG_SEG_LEN, {16'h0, len});
    wr_reg(`REG_CTRL, {24'h0, c});
  endtask
  task automatic wait_n(int cnt);
    for (int i = 0; i < 3000 && q.size() < cnt; i++)
      @(posedge clk);
  endtask
  task automatic pulse;
    @(posedge clk);
    gate <= 1'b1;
    repeat (4) @(posedge clk);
    gate <= 1'b0;
  endtask
  // Markers pass only in the two marker setups on extended memory
  function automatic logic [1:0] exp_marker(logic e, chan_cfg_type c, logic [1:0] m);
    return (e && (c == CFG_SINGLE_MKR || c == CFG_DUAL_MKR)) ? m : 2'h0;
  endfunction
  // Compare queued words against the segment, continuing from index k
  task automatic stream(logic e, chan_cfg_type c, int cnt);
    logic [33:0] w, x;
    wait_n(cnt);
    if (q.size() < cnt)
      chk("count", cnt, q.size());
    repeat (cnt)
    begin
      w = q.pop_front();
      x = u_far.sample_word(s + 16'(k % l));
      k++;
      chk("ch1", x[7:0], w[7:0]);
      if (c == CFG_FOUR)
        chk("word", x[31:0], w[31:0]);
      chk("marker", exp_marker(e, c, x[33:32]), w[33:32]);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    {rst_n, wr, rd, gate, addr, wdata} = '0;
    void'($urandom(32'h5f0f));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wr_reg(4'hA, 32'hFFFF_FFFF);
    rd_reg(`REG_CTRL, rv);
    chk("ctrl", 32'h0, rv);
    rd_reg(`REG_SEG_LEN, rv);
    chk("len", 32'h1, rv);
    rd_reg(4'hA, rv);
    chk("unmapped", 32'h0, rv);
    $display("register test done");
    // Every configuration but duplicate, both memories
    for (int c = 0; c < 6; c++)
      for (int e = 0; e < 2; e++)
        if (c != 4)
        begin
          l = 16'($urandom_range(5, 1));
          play(l, {3'(c), RUN_CONTINUOUS, 1'(e), 1'b1});
          stream(1'(e), chan_cfg_type'(c), 12);
        end
    rd_reg(`REG_STATUS, rv);
    chk("state", 2'h2, rv[1:0]);
    $display("continuous test done");
    for (int m = 1; m < 3; m++)
    begin
      l = 3;
      play(l, {CFG_FOUR, 2'(m), 1'b0, 1'b1});
      repeat (30) @(posedge clk);
      chk("early", 0, q.size());
      pulse();
      stream(1'b0, CFG_FOUR, 10);
    end
    $display("internal start test done");
    l = 4;
    play(l, {CFG_DUAL_MKR, RUN_TRIGGERED, 1'b1, 1'b1});
    repeat (2)
    begin
      k = 0;
      pulse();
      repeat (80) @(posedge clk);
      chk("once", 4, q.size());
      stream(1'b1, CFG_DUAL_MKR, 4);
    end
    // Inverted polarity: idle pin high, the trigger is the pin falling low
    play(l, {1'b1, CFG_DUAL_MKR, RUN_TRIGGERED, 1'b1, 1'b1});
    gate <= 1'b1;
    repeat (30) @(posedge clk);
    chk("early", 0, q.size());
    gate <= 1'b0;
    repeat (80) @(posedge clk);
    chk("once", 4, q.size());
    stream(1'b1, CFG_DUAL_MKR, 4);
    $display("triggered test done");
    l = 5;
    play(l, {CFG_FOUR, RUN_GATED, 1'b1, 1'b1});
    gate <= 1'b1;
    stream(1'b1, CFG_FOUR, 8);
    gate <= 1'b0;
    repeat (40) @(posedge clk);
    n = q.size();
    repeat (40) @(posedge clk);
    chk("paused", n, q.size());
    gate <= 1'b1;
    stream(1'b1, CFG_FOUR, n + 6);
    gate <= 1'b0;
    $display("gated test done");
    for (int j = 0; j < 2; j++)
    begin
      sk = j ? 4'($urandom_range(15, 1)) : 4'h0;
      wr_reg(`REG_SKEW, {28'h0, sk});
      rd_reg(`REG_SKEW, rv);
      chk("skew", {28'h0, sk}, rv);
      l = 6;
      play(l, {CFG_DUAL_DUP, RUN_CONTINUOUS, 1'b0, 1'b1});
      wait_n(40);
      for (int i = sk; i < 40; i++)
      begin
        chk("copy2", q[i - sk][7:0], q[i][15:8]);
        chk("copy3", q[i - sk][31:24], q[i][23:16]);
      end
    end
    $display("duplicate test done");
    end_sim();
  end
  // Whole run is well under this span
  initial
  begin
    #200000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire

// *** waveform_playback_run_control_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module waveform_playback_run_control_properties
  import playback_pkg::*;
  #(
    parameter int ADDR_W = 16
  )
  (
    input wire logic              ref_clk_i,
    input wire logic              rst_n_i,
    input wire logic [3:0]        reg_addr_i,
    input wire logic [31:0]       reg_wdata_i,
    input wire logic              reg_wr_i,
    input wire logic              reg_rd_i,
    input wire logic [31:0]       reg_rdata_o,
    input wire logic              trig_gate_i,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic              mem_rd_o,
    input wire mem_word_type      mem_data_i,
    input wire dac_word_type      dac_data_o,
    input wire logic              dac_valid_o,
    input wire logic              dac_ready_i,
    input wire logic [1:0]        marker_o,
    input wire logic [1:0]        marker_n_o
  );
  logic [7:0]  ctrl_reg;
  logic [15:0] start_reg;
  logic [15:0] len_reg;
  logic [3:0]  skew_reg;
  logic [3:0]  quiet_reg;
  logic        mk_en;
  logic        settled;
  // Shadow of the written setup, so checks know the live mode
  always_ff @(posedge ref_clk_i)
    if (!rst_n_i)
    begin
      ctrl_reg <= 8'h00;
      start_reg <= 16'h0000;
      len_reg <= 16'h0001;
      skew_reg <= 4'h0;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == 4'h0)
        ctrl_reg <= reg_wdata_i[7:0];
      if (reg_addr_i == 4'h1)
        start_reg <= reg_wdata_i[15:0];
      if (reg_addr_i == 4'h2)
        len_reg <= (reg_wdata_i[15:0] == 16'h0) ? 16'h0001 : reg_wdata_i[15:0];
      if (reg_addr_i == 4'h3)
        skew_reg <= reg_wdata_i[3:0];
    end
  // Settle time after any write; mode changes need a few cycles to land
  always_ff @(posedge ref_clk_i)
    if (!rst_n_i || reg_wr_i)
      quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF)
      quiet_reg <= quiet_reg + 4'h1;
  assign mk_en = ctrl_reg[1] && (ctrl_reg[6:4] == 3'h1 || ctrl_reg[6:4] == 3'h3);
  assign settled = quiet_reg == 4'hF;
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  property p_mkr_pair;
    marker_n_o == ~marker_o;
  endproperty
  a_mkr_pair: assert property (p_mkr_pair)
    else $error("marker complement wrong");
  property p_mkr_off;
    settled && !mk_en |-> marker_o == 2'h0;
  endproperty
  a_mkr_off: assert property (p_mkr_off)
    else $error("marker seen in a markerless setup");
  property p_dup_zero;
    settled && ctrl_reg[6:4] == 3'h4 && skew_reg == 4'h0 && dac_valid_o
      |-> dac_data_o.ch2 == dac_data_o.ch1 && dac_data_o.ch3 == dac_data_o.ch4;
  endproperty
  a_dup_zero: assert property (p_dup_zero)
    else $error("duplicate channel differs at zero skew");
  property p_hold;
    dac_valid_o && !dac_ready_i && ctrl_reg[0] && !reg_wr_i
      |=> dac_valid_o && $stable(dac_data_o) && $stable(marker_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled word or marker changed");
  property p_idle;
    settled && !ctrl_reg[0] |-> !mem_rd_o && !dac_valid_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("activity while stopped");
  property p_gate_pause;
    (settled && ctrl_reg[1:0] == 2'h3 && ctrl_reg[3:2] == 2'h2 && !ctrl_reg[7]
      && !trig_gate_i) [*5] |-> !mem_rd_o;
  endproperty
  a_gate_pause: assert property (p_gate_pause)
    else $error("fetch while gate low");
  property p_addr_range;
    mem_rd_o |-> 16'(mem_addr_o - start_reg) < len_reg;
  endproperty
  a_addr_range: assert property (p_addr_range)
    else $error("fetch outside segment");
  property p_no_pause;
    settled && ctrl_reg[0] && ctrl_reg[3:2] == 2'h0 && dac_valid_o && dac_ready_i
      |=> ##[0:5] dac_valid_o;
  endproperty
  a_no_pause: assert property (p_no_pause)
    else $error("gap in continuous output");
endmodule
bind waveform_playback_run_control waveform_playback_run_control_properties
  #(.ADDR_W(ADDR_W)) u_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .trig_gate_i(trig_gate_i),
  .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_data_i(mem_data_i),
  .dac_data_o(dac_data_o), .dac_valid_o(dac_valid_o), .dac_ready_i(dac_ready_i),
  .marker_o(marker_o), .marker_n_o(marker_n_o));
`default_nettype wire
